// ### rtl/dp_sink_event_audio_ctrl_pkg.sv
// Package for the sink control, event and audio block.
// Assumes a 32-bit Avalon-MM register slave, word-aligned byte addresses.
package dp_sink_event_audio_ctrl_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CORE_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TRAIN_CTRL = 12'h004;
  localparam logic [11:0] ADDR_PHY_STATE = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [11:0] ADDR_IRQ_CAUSE = 12'h014;
  localparam logic [11:0] ADDR_AUD_CTRL = 12'h300;
  localparam logic [11:0] ADDR_AUD_STATUS = 12'h304;
  localparam logic [11:0] ADDR_AUD_M = 12'h308;
  localparam logic [11:0] ADDR_AUD_N = 12'h30C;
  localparam logic [11:0] ADDR_INFO_BASE = 12'h320;
  localparam logic [11:0] ADDR_EXT_BASE = 12'h340;
  localparam logic [11:0] ADDR_MSA_BASE = 12'h500;
  localparam logic [11:0] ADDR_MSA_LAST = 12'h530;
  // Packet buffers hold eight words
  localparam int PKT_WORDS = 8;
  localparam logic [2:0] PKT_LAST = 3'h7;
  // Attribute words 0x500..0x530
  localparam int MSA_WORDS = 13;
  // Interrupt cause bit positions
  localparam int IRQ_MODE = 0;
  localparam int IRQ_NOVID = 1;
  localparam int IRQ_VBLANK = 2;
  localparam int IRQ_MCHG = 3;
  localparam int IRQ_TLOST = 4;
  localparam int IRQ_INFO = 5;
  localparam int IRQ_EXT = 6;
  localparam int IRQ_BITS = 7;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RST = 7'h00;
  // Audio status bits
  localparam int AST_INFO = 0;
  localparam int AST_EXT = 1;
  // Audio control encodings
  localparam logic [31:0] AUD_DISABLE = 32'h0000_0000;
  localparam logic [31:0] AUD_ENABLE = 32'h0000_0001;

  // Video status from the main link front end
  typedef struct packed {
    logic [15:0] vres;
    logic [15:0] hres;
    logic no_video;
    logic mode_change;
    logic trained;
  } video_state_t;

  // Incoming packet word
  typedef struct packed {
    logic valid;
    logic is_ext;
    logic [2:0] idx;
    logic [31:0] data;
  } pkt_word_t;
endpackage : dp_sink_event_audio_ctrl_pkg

// ### rtl/dp_sink_event_audio_ctrl.sv
// Control, event and audio register logic of a video link receiver.
// Assumes link-side inputs are already in core_clk_i domain except the
// plug detect pin, which is synchronised here.
`timescale 1ns/10ps

module dp_sink_event_audio_ctrl #(
  parameter int LANES = 4,        // Active lane count
  parameter int MN_W = 24         // M/N value width
) (
  input wire logic core_clk_i,    // 10 MHz clock
  input wire logic rst_n_i,       // Synchronous reset, active low
  // Avalon-MM slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Link side
  input wire logic cable_present_i,  // Plug detect pin, async
  output logic hot_plug_o,
  input wire logic aux_req_i,
  output logic aux_req_accept_o,
  input wire logic vid_valid_i,
  output logic vid_pass_o,
  input wire dp_sink_event_audio_ctrl_pkg::video_state_t vstate_i,
  input wire logic [31:0] msa_word_i [13],
  input wire logic [MN_W-1:0] vid_m_i,
  input wire logic [MN_W-1:0] vid_n_i,
  output logic [MN_W-1:0] vid_m_o,
  output logic [MN_W-1:0] vid_n_o,
  output logic vid_mn_update_o,
  // Phy_state_reg
  input wire logic [LANES-1:0] lane_align_i,
  input wire logic [LANES-1:0] sym_lock_i,
  input wire logic pll_lock_i,
  input wire logic reset_done_i,
  output logic train_mode_o,
  // Audio
  input wire dp_sink_event_audio_ctrl_pkg::pkt_word_t pkt_i,
  input wire logic [MN_W-1:0] aud_m_i,
  input wire logic [MN_W-1:0] aud_n_i,
  output logic [MN_W-1:0] audio_m_value_o,
  output logic [MN_W-1:0] audio_n_value_o,
  output logic audio_enable_o,
  output logic audio_flush_o,
  output logic irq_o
);
  import dp_sink_event_audio_ctrl_pkg::*;

  // Register state
  logic core_en_r;                 // Core enable
  logic train_mode_r;              // Training mode
  logic aud_en_r;                  // Audio enable
  logic flush_r;                   // One-cycle flush pulse
  logic [IRQ_BITS-1:0] mask_r;     // Interrupt mask
  logic [IRQ_BITS-1:0] cause_r;    // Sticky causes
  logic [31:0] info_mem [PKT_WORDS]; // Info packet buffer
  logic [31:0] ext_mem [PKT_WORDS];  // Extension packet buffer
  logic info_full_r;               // Info buffer unread
  logic ext_full_r;                // Extension buffer unread
  logic [31:0] rdata_r;            // Read data
  logic rd_ack_r;                  // Read answered
  // Event trackers
  logic [15:0] vres_r;
  logic [15:0] hres_r;
  logic seen_video_r;              // Video seen since reset or replug
  logic novid_r;
  logic trained_r;
  logic [MN_W-1:0] vm_r;
  logic [MN_W-1:0] vn_r;
  logic mn_upd_r;
  logic [MN_W-1:0] am_r;
  logic [MN_W-1:0] an_r;
  // Plug detect synchroniser
  logic plug_s1_r;
  logic plug_s2_r;
  logic plug_prev_r;

  // Address word index within a region
  function automatic logic [9:0] word_idx(input logic [11:0] a,
                                          input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[11:2];
  endfunction : word_idx

  // Address decode
  wire logic in_info = avs_address_i[11:5] == ADDR_INFO_BASE[11:5];
  wire logic in_ext = avs_address_i[11:5] == ADDR_EXT_BASE[11:5];
  wire logic in_msa = avs_address_i >= ADDR_MSA_BASE &&
                      avs_address_i <= ADDR_MSA_LAST;
  wire logic [2:0] pkt_idx = avs_address_i[4:2];
  wire logic [9:0] msa_idx = word_idx(avs_address_i, ADDR_MSA_BASE);
  // Reads take one wait cycle; writes take effect at once
  assign avs_waitrequest_o = avs_read_i && !rd_ack_r;
  wire logic rd_take = avs_read_i && rd_ack_r;
  wire logic wr_take = avs_write_i;

  // Reading the last buffer word frees the buffer
  wire logic info_rd_done = rd_take && in_info && pkt_idx == PKT_LAST;
  wire logic ext_rd_done = rd_take && in_ext && pkt_idx == PKT_LAST;
  wire logic cause_rd = rd_take && avs_address_i == ADDR_IRQ_CAUSE;

  // Replug edge clears training, audio and event state; core enable is kept
  wire logic replug = plug_s2_r && !plug_prev_r;

  // Link events, only while the core runs
  wire logic res_chg = core_en_r && vstate_i.trained && !vstate_i.no_video &&
    (!seen_video_r || vstate_i.vres != vres_r ||
     vstate_i.hres != hres_r);
  wire logic novid_ev = core_en_r && vstate_i.no_video && !novid_r;
  wire logic vblank_ev = core_en_r && !vstate_i.no_video && novid_r;
  wire logic mchg_ev = core_en_r && vstate_i.mode_change;
  wire logic tlost_ev = core_en_r && trained_r &&
                        (!vstate_i.trained || !plug_s2_r);
  // Packet acceptance drops words while buffer unread
  wire logic info_wr = pkt_i.valid && !pkt_i.is_ext && aud_en_r &&
                       core_en_r && !info_full_r;
  wire logic ext_wr = pkt_i.valid && pkt_i.is_ext && aud_en_r &&
                      core_en_r && !ext_full_r;
  wire logic info_last = info_wr && pkt_i.idx == PKT_LAST;
  wire logic ext_last = ext_wr && pkt_i.idx == PKT_LAST;

  wire logic [IRQ_BITS-1:0] ev_vec = {ext_last, info_last, tlost_ev,
                                      mchg_ev, vblank_ev, novid_ev,
                                      res_chg};
  // Read clears only the bits handed out one edge earlier; set wins
  wire logic [IRQ_BITS-1:0] cause_nxt =
    (cause_r & ~(cause_rd ? rdata_r[IRQ_BITS-1:0] : {IRQ_BITS{1'b0}})) |
    ev_vec;

  wire logic [31:0] phy_state_reg = {8'h00, 6'h00, reset_done_i,
    pll_lock_i, 8'(sym_lock_i), 8'(lane_align_i)};

  // Read multiplexer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_info) begin
      rd_mux = info_mem[pkt_idx];
    end else if (in_ext) begin
      rd_mux = ext_mem[pkt_idx];
    end else if (in_msa) begin
      rd_mux = msa_word_i[msa_idx[3:0]];
    end else begin
      case (avs_address_i)
        ADDR_CORE_CTRL: rd_mux = {31'h0, core_en_r};
        ADDR_TRAIN_CTRL: rd_mux = {31'h0, train_mode_r};
        ADDR_PHY_STATE: rd_mux = phy_state_reg;
        ADDR_IRQ_MASK: rd_mux = 32'(mask_r);
        ADDR_IRQ_CAUSE: rd_mux = 32'(cause_r);
        ADDR_AUD_CTRL: rd_mux = {31'h0, aud_en_r};
        ADDR_AUD_STATUS: rd_mux = {30'h0, ext_full_r, info_full_r};
        ADDR_AUD_M: rd_mux = 32'(am_r);
        ADDR_AUD_N: rd_mux = 32'(an_r);
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Plug synchroniser
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      // Plugged level, so leaving reset makes no false replug edge
      plug_s1_r <= 1'b1;
      plug_s2_r <= 1'b1;
      plug_prev_r <= 1'b1;
    end else begin
      plug_s1_r <= cable_present_i;
      plug_s2_r <= plug_s1_r;
      plug_prev_r <= plug_s2_r;
    end
  end

  // Bus read answer
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      rd_ack_r <= avs_read_i && !rd_ack_r;
      if (avs_read_i && !rd_ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end
  assign avs_readdata_o = rdata_r;

  // Control registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      core_en_r <= 1'b0;
      train_mode_r <= 1'b0;
      aud_en_r <= 1'b0;
      flush_r <= 1'b0;
      mask_r <= IRQ_MASK_RST;
    end else begin
      flush_r <= 1'b0;
      if (replug) begin
        train_mode_r <= 1'b0;
        aud_en_r <= 1'b0;
        flush_r <= 1'b1;
      end
      if (wr_take) begin
        case (avs_address_i)
          ADDR_CORE_CTRL: core_en_r <= avs_writedata_i[0];
          ADDR_TRAIN_CTRL: train_mode_r <= avs_writedata_i[0];
          ADDR_IRQ_MASK: mask_r <= avs_writedata_i[IRQ_BITS-1:0];
          ADDR_AUD_CTRL: begin
            if (avs_writedata_i == AUD_DISABLE) begin
              aud_en_r <= 1'b0;
              flush_r <= 1'b1;
            end else if (avs_writedata_i == AUD_ENABLE) begin
              aud_en_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Packet buffers and status
  always_ff @(posedge core_clk_i) begin
    if (info_wr) info_mem[pkt_i.idx] <= pkt_i.data;
    if (ext_wr) ext_mem[pkt_i.idx] <= pkt_i.data;
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || flush_r) begin
      info_full_r <= 1'b0;
      ext_full_r <= 1'b0;
    end else begin
      info_full_r <= info_last || (info_full_r && !info_rd_done);
      ext_full_r <= ext_last || (ext_full_r && !ext_rd_done);
    end
  end

  // Event trackers and interrupt causes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || replug) begin
      vres_r <= 16'h0000;
      hres_r <= 16'h0000;
      seen_video_r <= 1'b0;
      novid_r <= 1'b0;
      trained_r <= 1'b0;
      cause_r <= {IRQ_BITS{1'b0}};
    end else begin
      cause_r <= cause_nxt;
      trained_r <= core_en_r && vstate_i.trained && plug_s2_r;
      if (core_en_r) begin
        novid_r <= vstate_i.no_video;
      end
      if (res_chg) begin
        vres_r <= vstate_i.vres;
        hres_r <= vstate_i.hres;
        seen_video_r <= 1'b1;
      end
    end
  end

  // M/N capture
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      vm_r <= '0;
      vn_r <= '0;
      mn_upd_r <= 1'b0;
      am_r <= '0;
      an_r <= '0;
    end else begin
      vm_r <= vid_m_i;
      vn_r <= vid_n_i;
      mn_upd_r <= vid_m_i != vm_r || vid_n_i != vn_r;
      am_r <= aud_m_i;
      an_r <= aud_n_i;
    end
  end

  // Outputs
  assign hot_plug_o = core_en_r;
  assign aux_req_accept_o = aux_req_i && core_en_r;
  assign vid_pass_o = vid_valid_i && core_en_r && !train_mode_r;
  assign train_mode_o = train_mode_r && core_en_r;
  assign vid_m_o = vm_r;
  assign vid_n_o = vn_r;
  assign vid_mn_update_o = mn_upd_r;
  assign audio_m_value_o = am_r;
  assign audio_n_value_o = an_r;
  assign audio_enable_o = aud_en_r;
  assign audio_flush_o = flush_r;
  assign irq_o = |(cause_r & mask_r);

  // Checks
  a_hpd_follows_en: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) wr_take && avs_address_i == ADDR_CORE_CTRL
    |=> hot_plug_o == $past(avs_writedata_i[0]))
    else $error("hot plug differs from written enable");
  a_aux_ignored: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) !core_en_r |-> !aux_req_accept_o && !vid_pass_o)
    else $error("disabled core answered link");
  a_train_block: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) train_mode_r |-> !vid_pass_o)
    else $error("video passed during training");
  a_mn_update: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) $changed(vid_m_i) |=> vid_mn_update_o)
    else $error("M change without update");
  a_aud_disable: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) wr_take && avs_address_i == ADDR_AUD_CTRL &&
    avs_writedata_i == AUD_DISABLE |=> !audio_enable_o && audio_flush_o
    ##1 !info_full_r && !ext_full_r)
    else $error("audio disable did not flush");
  a_pkt_drop: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) info_full_r |-> !info_wr)
    else $error("packet accepted into unread buffer");
  a_status_clear: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) info_rd_done && !info_last && !replug
    |=> !info_full_r)
    else $error("status stayed after buffer read");
  a_irq_level: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) ev_vec[IRQ_MODE] && mask_r[IRQ_MODE] &&
    !wr_take && !replug |=> irq_o)
    else $error("unmasked cause gave no interrupt");
  a_cause_sticky: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) cause_r[IRQ_MODE] && !cause_rd && !replug
    |=> cause_r[IRQ_MODE])
    else $error("cause bit lost before read");
  a_novid_irq: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) novid_ev && !replug |=> cause_r[IRQ_NOVID])
    else $error("no video cause missing");
  c_info_pkt: cover property (@(posedge core_clk_i) info_last);
  c_mode_irq: cover property (@(posedge core_clk_i) res_chg);
  c_tlost: cover property (@(posedge core_clk_i) tlost_ev);
  c_replug: cover property (@(posedge core_clk_i) replug);
endmodule : dp_sink_event_audio_ctrl

// ### verif/link_source_model.sv
// Model of the upstream link source that feeds the sink block.
// Assumes the bench calls send_pkt just after a rising clock edge.
`timescale 1ns/10ps
module link_source_model (
  input wire logic clk_i, // Sink core clock
  output logic cable_o, // Plug detect level
  output logic aux_o, // AUX request level
  output logic vvalid_o, // Main link video valid
  output dp_sink_event_audio_ctrl_pkg::video_state_t vstate_o, // Stream
  output logic [31:0] msa_o [13], // Attribute words
  output logic [23:0] vm_o, // Video M
  output logic [23:0] vn_o, // Video N
  output dp_sink_event_audio_ctrl_pkg::pkt_word_t pkt_o, // Packet word
  output logic [23:0] am_o, // Audio M
  output logic [23:0] an_o // Audio N
);
  import dp_sink_event_audio_ctrl_pkg::*;

  // Plugged, trained, idle link at power up
  initial begin
    cable_o = 1'b1;
    aux_o = 1'b0;
    vvalid_o = 1'b0;
    vstate_o = '{16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1};
    foreach (msa_o[i]) msa_o[i] = 32'h0000_1000 + i;
    vm_o = 24'h000010;
    vn_o = 24'h000020;
    pkt_o = '{1'b0, 1'b0, 3'h0, 32'h0000_0000};
    am_o = 24'h000000;
    an_o = 24'h000000;
  end

  // Sends a whole eight-word packet, one word a cycle
  task automatic send_pkt(input logic ext, input logic [31:0] base);
    for (int i = 0; i < 8; i++) begin
      pkt_o <= '{1'b1, ext, i[2:0], base + i};
      @(posedge clk_i);
    end
    // Idle data is garbage, never the last word
    pkt_o <= '{1'b0, ext, 3'h0, ~(base + 32'h0000_0007)};
  endtask : send_pkt
endmodule : link_source_model

// ### verif/dp_sink_event_audio_ctrl_tb_top.sv
// Self-checking bench for the sink control, event and audio block.
// Assumes the package and the link source model are compiled first.
`timescale 1ns/10ps
module dp_sink_event_audio_ctrl_tb_top;
  import dp_sink_event_audio_ctrl_pkg::*;
  logic clk, rst_n, rd, wr, waitreq; // Clock, reset, bus control
  logic [11:0] addr; // Bus address
  logic [31:0] wdata, rdata, rv; // Bus data, last read value
  logic cable, aux, vvalid, hot, aux_acc, vpass, vupd, tmode; // Link
  logic pll, rdone, aen, aflush, irq, flush_seen; // Status, audio
  logic [3:0] align, slock; // Lane status
  logic [23:0] vm, vn, vm_o, vn_o, am, an, am_o, an_o; // M/N values
  logic [31:0] main_stream_attributes [13]; // Attribute words
  video_state_t vst; // Stream state
  pkt_word_t pkt; // Packet word
  int mismatches, total_checks, cycles; // Counters

  // Far-side source
  link_source_model src (.clk_i(clk), .cable_o(cable), .aux_o(aux),
    .vvalid_o(vvalid), .vstate_o(vst), .msa_o(main_stream_attributes), .vm_o(vm),
    .vn_o(vn), .pkt_o(pkt), .am_o(am), .an_o(an));

  dp_sink_event_audio_ctrl #(.LANES(4), .MN_W(24)) uut (
    .core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .cable_present_i(cable), .hot_plug_o(hot), .aux_req_i(aux),
    .aux_req_accept_o(aux_acc), .vid_valid_i(vvalid), .vid_pass_o(vpass),
    .vstate_i(vst), .msa_word_i(main_stream_attributes), .vid_m_i(vm), .vid_n_i(vn),
    .vid_m_o(vm_o), .vid_n_o(vn_o), .vid_mn_update_o(vupd),
    .lane_align_i(align), .sym_lock_i(slock), .pll_lock_i(pll),
    .reset_done_i(rdone), .train_mode_o(tmode), .pkt_i(pkt),
    .aud_m_i(am), .aud_n_i(an), .audio_m_value_o(am_o),
    .audio_n_value_o(an_o), .audio_enable_o(aen),
    .audio_flush_o(aflush), .irq_o(irq));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard and flush pulse catcher
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (aflush === 1'b1) flush_seen <= 1'b1;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up;
    end
  end

  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Register value compare
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk32

  // Port level compare
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask : chk1

  // One bus cycle, held until wait is seen low
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    // Only the bench timeout ends a wait that never comes
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  // Read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk32(rv, exp);
  endtask : rchk

  // Lets an event land, then reads the cause bits under a mask
  task automatic cause_is(input logic [31:0] exp, input logic [31:0] m);
    repeat (3) @(posedge clk);
    bus(1'b0, ADDR_IRQ_CAUSE, 32'h0000_0000);
    chk32(rv & m, exp);
  endtask : cause_is

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {rd, wr, pll, rdone, flush_seen} = 5'h00;
    {addr, wdata, align, slock} = 52'h0;
    {mismatches, total_checks, cycles} = 96'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    src.aux_o <= 1'b1;
    src.vvalid_o <= 1'b1;
    @(negedge clk);
    chk1(hot, 1'b0);
    chk1(aux_acc, 1'b0);
    chk1(vpass, 1'b0);
    bus(1'b1, ADDR_CORE_CTRL, 32'h0000_0001);
    @(negedge clk);
    chk1(hot, 1'b1);
    chk1(aux_acc, 1'b1);
    chk1(vpass, 1'b1);
    bus(1'b1, ADDR_TRAIN_CTRL, 32'h0000_0001);
    @(negedge clk);
    chk1(tmode, 1'b1);
    chk1(vpass, 1'b0);
    bus(1'b1, ADDR_TRAIN_CTRL, 32'h0000_0000);
    {align, slock, pll, rdone} <= {4'hA, 4'h5, 2'h3};
    rchk(ADDR_PHY_STATE, 32'h0003_050A);
    rchk(12'h0FC, 32'h0000_0000);
    done("control");
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_007F);
    rchk(ADDR_IRQ_MASK, 32'h0000_007F);
    bus(1'b0, ADDR_IRQ_CAUSE, 32'h0000_0000);
    src.vstate_o.vres <= 16'h0438;
    src.vstate_o.hres <= 16'h0780;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk1(irq, 1'b1);
    cause_is(32'h0000_0001, 32'hFFFF_FFFF);
    cause_is(32'h0000_0000, 32'hFFFF_FFFF);
    src.vstate_o.no_video <= 1'b1;
    cause_is(32'h0000_0002, 32'h0000_0002);
    src.vstate_o.no_video <= 1'b0;
    cause_is(32'h0000_0004, 32'h0000_0004);
    src.vstate_o.mode_change <= 1'b1;
    @(posedge clk);
    src.vstate_o.mode_change <= 1'b0;
    cause_is(32'h0000_0008, 32'h0000_0008);
    src.vstate_o.trained <= 1'b0;
    cause_is(32'h0000_0010, 32'h0000_0010);
    src.vstate_o.trained <= 1'b1;
    rchk(ADDR_MSA_BASE, 32'h0000_1000);
    rchk(ADDR_MSA_LAST, 32'h0000_100C);
    src.vm_o <= 24'h00ABCD;
    @(posedge clk);
    @(negedge clk);
    chk1(vupd, 1'b1);
    chk32({8'h00, vm_o}, 32'h0000_ABCD);
    chk32({8'h00, vn_o}, 32'h0000_0020);
    @(negedge clk);
    chk1(vupd, 1'b0);
    done("events");
    {src.am_o, src.an_o} <= {24'h001234, 24'h005678};
    bus(1'b1, ADDR_AUD_CTRL, AUD_ENABLE);
    bus(1'b1, ADDR_AUD_CTRL, 32'h0000_0002);
    @(negedge clk);
    chk1(aen, 1'b1);
    chk32({an_o, am_o[7:0]}, 32'h0056_7834);
    rchk(ADDR_AUD_M, 32'h0000_1234);
    rchk(ADDR_AUD_N, 32'h0000_5678);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0020);
    bus(1'b0, ADDR_IRQ_CAUSE, 32'h0000_0000);
    // Info then extension buffer, second packet must be dropped
    for (int e = 0; e < 2; e++) begin
      src.send_pkt(e[0], 32'hA000_0000 + e * 16);
      rchk(ADDR_AUD_STATUS, 32'h0000_0001 << e);
      @(negedge clk);
      chk1(irq, e == 0);
      rchk(ADDR_IRQ_CAUSE, 32'h0000_0020 << e);
      src.send_pkt(e[0], 32'hB000_0000);
      for (int i = 0; i < 8; i++)
        rchk(12'(ADDR_INFO_BASE + e * 32 + i * 4),
             32'hA000_0000 + e * 16 + i);
      rchk(ADDR_AUD_STATUS, 32'h0000_0000);
    end
    flush_seen <= 1'b0;
    bus(1'b1, ADDR_AUD_CTRL, AUD_DISABLE);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk1(aen, 1'b0);
    chk1(flush_seen, 1'b1);
    done("audio");
    bus(1'b1, ADDR_AUD_CTRL, AUD_ENABLE);
    bus(1'b1, ADDR_TRAIN_CTRL, 32'h0000_0001);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_007F);
    src.cable_o <= 1'b0;
    cause_is(32'h0000_0010, 32'h0000_0010);
    src.cable_o <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk1(hot, 1'b1);
    chk1(tmode, 1'b0);
    chk1(aen, 1'b0);
    done("replug");
    wrap_up;
  end
endmodule : dp_sink_event_audio_ctrl_tb_top
